// ==== src/alu_defines.svh ====
// opcode, format and timing constants for the add and bit-logic datapath
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH

// opcode group bases, offsets 0..4 select the operand form
`define OPC_ADC_BASE    8'h12
`define OPC_ADD_BASE    8'h02
`define OPC_AND_BASE    8'h52
`define OPC_BAND        8'h67
`define OPC_GROUP_SPAN  4'h4

// instruction byte lengths
`define LEN_SHORT       2'h2
`define LEN_LONG        2'h3

// execution cycle counts
`define CYC_SHORT       4'h4
`define CYC_LONG        4'h6

// flag vector reset value
`define FLAGS_RST       6'h00

// bit-logic second byte layout
`define BIT_SEL_POS     0
`define BIT_IDX_LSB     1
`define BIT_IDX_MSB     3
`define BIT_REG_LSB     4
`define BIT_REG_MSB     7

`endif

// ==== src/alu_pkg.sv ====
// types shared by the add and bit-logic datapath and its decoder
package alu_pkg;

	typedef enum logic [1:0] {
		OP_ADC,
		OP_ADD,
		OP_AND,
		OP_BAND
	} op_t;

	typedef enum logic [2:0] {
		FORM_WORK_PAIR,
		FORM_WORK_IND,
		FORM_REG_PAIR,
		FORM_REG_IND,
		FORM_IMM,
		FORM_BIT
	} form_t;

	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
		logic d;
		logic h;
	} flags_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] byte2;
		logic [7:0] byte3;
	} cmd_t;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} rf_wr_t;

	typedef struct packed {
		logic         legal;
		op_t          op;
		form_t        form;
		logic [1:0]   nbytes;
		logic [3:0]   ncycles;
	} dec_t;

endpackage

// ==== src/alu_decode.sv ====
// opcode decoder: operation, operand form, length and cycle count
`timescale 1ns/1ps
`include "alu_defines.svh"

module alu_decode (
	// opcode in
	input  wire logic [7:0]    opcode,
	// decoded fields out
	output alu_pkg::dec_t      dec
);

	logic [7:0] off_adc;
	logic [7:0] off_add;
	logic [7:0] off_and;
	logic [2:0] form_idx;

	assign off_adc = opcode - `OPC_ADC_BASE;
	assign off_add = opcode - `OPC_ADD_BASE;
	assign off_and = opcode - `OPC_AND_BASE;

	always_comb begin
		dec          = '0;
		dec.op       = alu_pkg::OP_ADD;
		dec.form     = alu_pkg::FORM_WORK_PAIR;
		form_idx     = 3'h0;
		dec.nbytes   = `LEN_LONG;
		dec.ncycles  = `CYC_LONG;
		if (off_adc <= 8'(`OPC_GROUP_SPAN)) begin
			dec.legal = 1'b1;
			dec.op    = alu_pkg::OP_ADC;
			form_idx  = off_adc[2:0];
		end else if (off_add <= 8'(`OPC_GROUP_SPAN)) begin
			dec.legal = 1'b1;
			dec.op    = alu_pkg::OP_ADD;
			form_idx  = off_add[2:0];
		end else if (off_and <= 8'(`OPC_GROUP_SPAN)) begin
			dec.legal = 1'b1;
			dec.op    = alu_pkg::OP_AND;
			form_idx  = off_and[2:0];
		end else if (opcode == `OPC_BAND) begin
			dec.legal = 1'b1;
			dec.op    = alu_pkg::OP_BAND;
		end
		if (dec.op == alu_pkg::OP_BAND) begin
			dec.form = alu_pkg::FORM_BIT;
		end else begin
			case (form_idx)
				3'h0: dec.form = alu_pkg::FORM_WORK_PAIR;
				3'h1: dec.form = alu_pkg::FORM_WORK_IND;
				3'h2: dec.form = alu_pkg::FORM_REG_PAIR;
				3'h3: dec.form = alu_pkg::FORM_REG_IND;
				default: dec.form = alu_pkg::FORM_IMM;
			endcase
		end
		if (dec.form == alu_pkg::FORM_WORK_PAIR) begin
			dec.ncycles = `CYC_SHORT;
		end
		if (dec.form == alu_pkg::FORM_WORK_PAIR || dec.form == alu_pkg::FORM_WORK_IND) begin
			dec.nbytes = `LEN_SHORT;
		end
	end

endmodule

// ==== src/add_and_bitlogic_alu.sv ====
// add, add-with-carry, byte and and bit-and datapath with operand fetch
// What this block does
// - add-with-carry writes dst plus src plus carry to dst; src untouched.
// - plain add writes dst plus src to dst, no carry in; src untouched.
// - after adds, carry flag is the carry out of bit 7.
// - after adds, zero and sign follow result; decimal-adjust flag cleared.
// - after adds, overflow set when like-signed operands give opposite-signed result.
// - after adds, half-carry is the carry out of bit 3.
// - byte and stores dst and src bitwise into dst; src untouched.
// - after byte and: zero, sign from bit 7, overflow cleared, others kept.
// - opcodes 12-16 adc, 02-06 add, 52-56 and; lowest is short form.
// - group offsets select work pair, work indirect, reg pair, reg indirect, immediate.
// - opcode 67 bit-and; selector picks dst bit0 or dst bit b form.
// - second byte splits into register, bit index, selector; one dst bit changes.
// - after bit-and: zero is the inverse of the result bit, sign cleared, other flags kept.
`timescale 1ns/1ps
`include "alu_defines.svh"

module add_and_bitlogic_alu (
	// clock and reset
	input  wire logic            core_clk,
	input  wire logic            sys_rst,
	// instruction from the sequencer
	input  wire logic            start,
	input  alu_pkg::cmd_t        cmd,
	input  alu_pkg::flags_t      flags_in,
	input  wire logic [3:0]      work_bank,
	output logic                 busy_q,
	output logic                 done_q,
	output logic                 illegal_q,
	output logic [1:0]           nbytes_q,
	output logic [3:0]           ncycles_q,
	// flag update
	output alu_pkg::flags_t      flags_q,
	output logic                 flags_we_q,
	// register file read port
	output logic                 rf_rd_req_q,
	output logic [7:0]           rf_rd_addr_q,
	input  wire logic            rf_rd_valid,
	input  wire logic [7:0]      rf_rd_data,
	// register file write port
	output alu_pkg::rf_wr_t      rf_wr_q
);

	typedef enum logic [2:0] {
		S_IDLE,
		S_IND,
		S_SRC,
		S_DST,
		S_WB
	} state_t;

	state_t          state_q;
	alu_pkg::dec_t   dec;
	alu_pkg::op_t    op_q;
	alu_pkg::flags_t fin_q;
	logic [7:0]      dst_addr_q;
	logic [7:0]      src_val_q;
	logic [7:0]      dst_val_q;
	logic [2:0]      bit_idx_q;
	logic            bit_sel_q;
	logic [7:0]      src_addr_d;
	logic [7:0]      dst_addr_d;
	logic            rd_take;

	// result path
	logic [7:0]      res;
	alu_pkg::flags_t flags_d;
	logic [8:0]      sum9;
	logic [4:0]      sum_lo;
	logic            cin;
	logic            rbit;

	// working registers sit in the bank selected by the pointer
	function automatic logic [7:0] work_addr(input logic [3:0] bank, input logic [3:0] r);
		return {bank, r};
	endfunction

	alu_decode u_decode (
		.opcode (cmd.opcode),
		.dec    (dec)
	);

	// operand addresses per form
	always_comb begin
		src_addr_d = cmd.byte2;
		dst_addr_d = cmd.byte3;
		unique case (dec.form)
			alu_pkg::FORM_WORK_PAIR,
			alu_pkg::FORM_WORK_IND: begin
				src_addr_d = work_addr(work_bank, cmd.byte2[3:0]);
				dst_addr_d = work_addr(work_bank, cmd.byte2[7:4]);
			end
			alu_pkg::FORM_REG_PAIR,
			alu_pkg::FORM_REG_IND: begin
				src_addr_d = cmd.byte2;
				dst_addr_d = cmd.byte3;
			end
			alu_pkg::FORM_IMM: begin
				src_addr_d = cmd.byte3;
				dst_addr_d = cmd.byte2;
			end
			alu_pkg::FORM_BIT: begin
				if (cmd.byte2[`BIT_SEL_POS]) begin
					src_addr_d = work_addr(work_bank, cmd.byte2[`BIT_REG_MSB:`BIT_REG_LSB]);
					dst_addr_d = cmd.byte3;
				end else begin
					src_addr_d = cmd.byte3;
					dst_addr_d = work_addr(work_bank, cmd.byte2[`BIT_REG_MSB:`BIT_REG_LSB]);
				end
			end
		endcase
	end

	assign rd_take = rf_rd_req_q && rf_rd_valid;

	// sequencing of operand fetch and write-back
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= S_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (start && dec.legal) begin
						if (dec.form == alu_pkg::FORM_WORK_IND || dec.form == alu_pkg::FORM_REG_IND) begin
							state_q <= S_IND;
						end else if (dec.form == alu_pkg::FORM_IMM) begin
							state_q <= S_DST;
						end else begin
							state_q <= S_SRC;
						end
					end
				end
				S_IND: if (rd_take) state_q <= S_SRC;
				S_SRC: if (rd_take) state_q <= S_DST;
				S_DST: if (rd_take) state_q <= S_WB;
				S_WB:  state_q <= S_IDLE;
			endcase
		end
	end

	// instruction fields held for the whole operation
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			op_q       <= alu_pkg::OP_ADD;
			fin_q      <= `FLAGS_RST;
			bit_idx_q  <= 3'h0;
			bit_sel_q  <= 1'b0;
			dst_addr_q <= 8'h00;
			nbytes_q   <= 2'h0;
			ncycles_q  <= 4'h0;
		end else if (state_q == S_IDLE && start && dec.legal) begin
			op_q       <= dec.op;
			fin_q      <= flags_in;
			bit_idx_q  <= cmd.byte2[`BIT_IDX_MSB:`BIT_IDX_LSB];
			bit_sel_q  <= cmd.byte2[`BIT_SEL_POS];
			dst_addr_q <= dst_addr_d;
			nbytes_q   <= dec.nbytes;
			ncycles_q  <= dec.ncycles;
		end
	end

	// operand capture; immediate byte stands in for the source value
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			src_val_q <= 8'h00;
			dst_val_q <= 8'h00;
		end else if (state_q == S_IDLE && start && dec.legal) begin
			src_val_q <= cmd.byte3;
		end else if (rd_take) begin
			// pointer data goes straight to the read address, not here
			unique case (state_q)
				S_SRC:   src_val_q <= rf_rd_data;
				S_DST:   dst_val_q <= rf_rd_data;
				default: src_val_q <= src_val_q;
			endcase
		end
	end

	// read request stays up until the register file answers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rf_rd_req_q  <= 1'b0;
			rf_rd_addr_q <= 8'h00;
		end else if (state_q == S_IDLE) begin
			rf_rd_req_q <= start && dec.legal;
			if (dec.form == alu_pkg::FORM_IMM) begin
				rf_rd_addr_q <= dst_addr_d;
			end else begin
				rf_rd_addr_q <= src_addr_d;
			end
		end else if (rd_take) begin
			rf_rd_req_q <= (state_q != S_DST);
			if (state_q == S_IND) begin
				rf_rd_addr_q <= rf_rd_data;
			end else begin
				rf_rd_addr_q <= dst_addr_q;
			end
		end
	end

	// arithmetic and logic
	always_comb begin
		cin     = (op_q == alu_pkg::OP_ADC) ? fin_q.c : 1'b0;
		sum9    = {1'b0, dst_val_q} + {1'b0, src_val_q} + {8'h00, cin};
		sum_lo  = {1'b0, dst_val_q[3:0]} + {1'b0, src_val_q[3:0]} + {4'h0, cin};
		flags_d = fin_q;
		res     = dst_val_q;
		rbit    = 1'b0;
		unique case (op_q)
			alu_pkg::OP_ADC,
			alu_pkg::OP_ADD: begin
				res       = sum9[7:0];
				flags_d.c = sum9[8];
				flags_d.z = (sum9[7:0] == 8'h00);
				flags_d.s = sum9[7];
				flags_d.d = 1'b0;
				flags_d.v = (dst_val_q[7] == src_val_q[7]) && (sum9[7] != dst_val_q[7]);
				flags_d.h = sum_lo[4];
			end
			alu_pkg::OP_AND: begin
				res       = dst_val_q & src_val_q;
				flags_d.z = (res == 8'h00);
				flags_d.s = res[7];
				flags_d.v = 1'b0;
			end
			alu_pkg::OP_BAND: begin
				if (bit_sel_q) begin
					rbit           = dst_val_q[bit_idx_q] & src_val_q[0];
					res[bit_idx_q] = rbit;
				end else begin
					rbit   = dst_val_q[0] & src_val_q[bit_idx_q];
					res[0] = rbit;
				end
				// overflow is undefined here; holding it costs nothing
				flags_d.z = ~rbit;
				flags_d.s = 1'b0;
			end
		endcase
	end

	// write-back: only the destination is ever written
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rf_wr_q    <= '0;
			flags_q    <= `FLAGS_RST;
			flags_we_q <= 1'b0;
			done_q     <= 1'b0;
		end else begin
			rf_wr_q.en <= (state_q == S_WB);
			flags_we_q <= (state_q == S_WB);
			done_q     <= (state_q == S_WB);
			if (state_q == S_WB) begin
				rf_wr_q.addr <= dst_addr_q;
				rf_wr_q.data <= res;
				flags_q      <= flags_d;
			end
		end
	end

	// status to the sequencer
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy_q    <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			illegal_q <= (state_q == S_IDLE) && start && !dec.legal;
			if (state_q == S_IDLE) begin
				busy_q <= start && dec.legal;
			end else if (state_q == S_WB) begin
				busy_q <= 1'b0;
			end
		end
	end

endmodule

// ==== testbench/alu_port_checker_sva.sv ====
// port assertions for the add and bit-logic datapath
`timescale 1ns/1ps
module alu_port_checker (
	// clock and reset
	input wire logic	core_clk,
	input wire logic	sys_rst,
	// command side
	input wire logic	start,
	input alu_pkg::cmd_t	cmd,
	input alu_pkg::flags_t	flags_in,
	input wire logic [3:0]	work_bank,
	input wire logic	busy_q,
	input wire logic	done_q,
	input wire logic	illegal_q,
	input wire logic [1:0]	nbytes_q,
	input wire logic [3:0]	ncycles_q,
	input alu_pkg::flags_t	flags_q,
	input wire logic	flags_we_q,
	// register file side
	input wire logic	rf_rd_req_q,
	input wire logic [7:0]	rf_rd_addr_q,
	input wire logic	rf_rd_valid,
	input wire logic [7:0]	rf_rd_data,
	input alu_pkg::rf_wr_t	rf_wr_q
);
	logic [7:0]	op_q, b2_q, b3_q;
	alu_pkg::flags_t	fl_q;
	logic [3:0]	lo;
	logic	legal;
	assign lo = cmd.opcode[3:0];
	assign legal = cmd.opcode == 8'h67 || (cmd.opcode[7:4] inside {4'h0, 4'h1, 4'h5} && lo inside {[4'h2:4'h6]});
	// command fields are valid only with start, so keep them for write-back
	always_ff @(posedge core_clk) begin
		if (start && !busy_q && legal) begin
			op_q <= cmd.opcode;
			b2_q <= cmd.byte2;
			b3_q <= cmd.byte3;
			fl_q <= flags_in;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_take;
		start && !busy_q && legal;
	endsequence
	sequence s_wb;
		done_q && flags_we_q && rf_wr_q.en && !busy_q;
	endsequence
	a_take_len: assert property (s_take |=> busy_q && nbytes_q == (($past(lo) inside {4'h2, 4'h3}) ? 2'h2 : 2'h3)
		&& ncycles_q == ($past(lo) == 4'h2 ? 4'h4 : 4'h6)) else $error("bad start or length");
	a_illegal_pulse: assert property (start && !busy_q && !legal |=> illegal_q && !busy_q ##1 !illegal_q)
		else $error("bad illegal pulse");
	a_wb_bound: assert property (s_take |-> ##[3:80] s_wb) else $error("no write-back");
	a_wb_single: assert property (done_q |-> s_wb ##1 !done_q) else $error("bad write-back pulse");
	a_add_flags: assert property (done_q && op_q[7:4] != 4'h5 && op_q != 8'h67 |-> !flags_q.d
		&& flags_q.z == (rf_wr_q.data == 8'h00) && flags_q.s == rf_wr_q.data[7]) else $error("add flags");
	a_and_flags: assert property (done_q && op_q[7:4] == 4'h5 |-> !flags_q.v && flags_q.s == rf_wr_q.data[7]
		&& {flags_q.c, flags_q.d, flags_q.h} == {fl_q.c, fl_q.d, fl_q.h}) else $error("and flags");
	a_band_flags: assert property (done_q && op_q == 8'h67 |-> !flags_q.s
		&& {flags_q.c, flags_q.d, flags_q.h} == {fl_q.c, fl_q.d, fl_q.h}) else $error("bit-and flags");
	a_dest_addr: assert property (done_q && op_q[3:0] inside {4'h4, 4'h5, 4'h6}
		|-> rf_wr_q.addr == (op_q[3:0] == 4'h6 ? b2_q : b3_q)) else $error("bad destination");
	a_ptr_first: assert property ((s_take and (lo == 4'h5)) |=> rf_rd_req_q && rf_rd_addr_q == $past(cmd.byte2))
		else $error("pointer not read first");
endmodule

// ==== testbench/rf_model.sv ====
// register file model behind the datapath read and write ports
`timescale 1ns/1ps
module rf_model (
	// clock
	input wire logic	core_clk,
	// read port
	input wire logic	rf_rd_req_q,
	input wire logic [7:0]	rf_rd_addr_q,
	output logic	rf_rd_valid,
	output logic [7:0]	rf_rd_data,
	// write port
	input alu_pkg::rf_wr_t	rf_wr_q
);
	logic [7:0]	mem [256];
	int	lat = 0;
	int	wait_q = 0;
	logic [7:0]	last_q = 8'h00;
	assign rf_rd_valid = rf_rd_req_q && wait_q >= lat;
	// inverted stale data off the answer, so an early capture shows up
	assign rf_rd_data = rf_rd_valid ? mem[rf_rd_addr_q] : ~last_q;
	always @(posedge core_clk) begin
		if (rf_rd_valid) begin
			last_q <= rf_rd_data;
			wait_q <= 0;
		end else if (rf_rd_req_q)
			wait_q <= wait_q + 1;
		if (rf_wr_q.en)
			mem[rf_wr_q.addr] <= rf_wr_q.data;
	end
endmodule

// ==== testbench/test_add_and_bitlogic_alu.sv ====
// self-checking bench for the add and bit-logic datapath
`timescale 1ns/1ps
module test_add_and_bitlogic_alu;
	logic	core_clk = 1'b0;
	logic	sys_rst = 1'b1;
	logic	start = 1'b0;
	alu_pkg::cmd_t	cmd = '0;
	alu_pkg::flags_t	flags_in = '0;
	logic [3:0]	work_bank = 4'h3;
	logic	busy_q, done_q, illegal_q, flags_we_q, rf_rd_req_q, rf_rd_valid;
	logic [1:0]	nbytes_q;
	logic [3:0]	ncycles_q;
	logic [7:0]	rf_rd_addr_q, rf_rd_data;
	alu_pkg::flags_t	flags_q;
	alu_pkg::rf_wr_t	rf_wr_q;
	int	err_total = 0;
	int	cmp_count = 0;

	always #2 core_clk = ~core_clk;

	add_and_bitlogic_alu add_and_bitlogic_alu_inst (.*);
	rf_model rf_model_inst (.*);

	function automatic logic [7:0] m(input logic [7:0] a);
		return rf_model_inst.mem[a];
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3, input alu_pkg::flags_t fl);
		logic [7:0] s, d, da, r;
		logic [8:0] sum;
		logic [4:0] hs;
		logic [2:0] k;
		logic cin;
		alu_pkg::flags_t ef;
		ef = fl;
		k = b2[0] ? b2[3:1] : 3'h0;
		cin = op[7:4] == 4'h1 ? fl.c : 1'b0;
		da = op[3:0] < 4'h4 ? {work_bank, b2[7:4]} : (op[3:0] == 4'h6 ? b2 : b3);
		case (op[3:0])
			4'h2: s = m({work_bank, b2[3:0]});
			4'h3: s = m(m({work_bank, b2[3:0]}));
			4'h4: s = m(b2);
			4'h5: s = m(m(b2));
			default: s = b3;
		endcase
		if (op == 8'h67) begin
			da = b2[0] ? b3 : {work_bank, b2[7:4]};
			s = b2[0] ? m({work_bank, b2[7:4]}) : m(b3);
			d = m(da);
			r = d;
			r[k] = b2[0] ? d[k] & s[0] : d[0] & s[b2[3:1]];
			ef.z = ~r[k];
			ef.s = 1'b0;
		end else begin
			d = m(da);
			sum = {1'b0, d} + {1'b0, s} + {8'h00, cin};
			hs = {1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, cin};
			r = op[7:4] == 4'h5 ? d & s : sum[7:0];
			ef.z = r == 8'h00;
			ef.s = r[7];
			ef.v = op[7:4] != 4'h5 && d[7] == s[7] && r[7] != d[7];
			if (op[7:4] != 4'h5) begin
				ef.c = sum[8];
				ef.h = hs[4];
				ef.d = 1'b0;
			end
		end
		@(posedge core_clk);
		start <= 1'b1;
		cmd <= {op, b2, b3};
		flags_in <= fl;
		@(posedge core_clk);
		// held start with another command while busy must be dropped
		cmd <= {8'h02, ~b2, ~b3};
		@(posedge core_clk);
		start <= 1'b0;
		@(negedge core_clk);
		chk(busy_q, 1'b1);
		chk({nbytes_q, ncycles_q}, op[3:0] == 4'h2 ? 6'h24 : (op[3:0] == 4'h3 ? 6'h26 : 6'h36));
		for (int n = 0; n < 80 && done_q !== 1'b1; n++)
			@(negedge core_clk);
		chk(done_q, 1'b1);
		chk(rf_wr_q.addr, da);
		chk(rf_wr_q.data, r);
		chk(flags_q, ef);
		// write-back lands on the next edge; the next expectation must see it
		@(negedge core_clk);
	endtask

	task automatic t_groups(input int lat);
		logic [7:0] grp [3] = '{8'h00, 8'h10, 8'h50};
		rf_model_inst.lat = lat;
		for (int i = 0; i < 256; i++)
			rf_model_inst.mem[i] = 8'(i * 109 + 41);
		foreach (grp[g])
			for (int lo = 2; lo < 7; lo++) begin
				run(grp[g] | 8'(lo), 8'h12, 8'h45, 6'h3f);
				run(grp[g] | 8'(lo), 8'h12, 8'h45, 6'h00);
			end
	endtask

	task automatic t_edges();
		rf_model_inst.mem[8'h31] = 8'h7f;
		rf_model_inst.mem[8'h32] = 8'h01;
		run(8'h02, 8'h12, 8'h00, 6'h3f);
		chk({rf_wr_q.data, flags_q}, {8'h80, 6'h0d});
		rf_model_inst.mem[8'h31] = 8'hff;
		rf_model_inst.mem[8'h32] = 8'h00;
		run(8'h12, 8'h12, 8'h00, 6'h20);
		chk({rf_wr_q.data, flags_q}, {8'h00, 6'h31});
	endtask

	task automatic t_band();
		work_bank = 4'h7;
		for (int k = 0; k < 16; k++)
			run(8'h67, {4'(k + 1), 3'(k), 1'(k >> 3)}, 8'h50 + 8'(k), 6'h2a);
	endtask

	task automatic t_illegal();
		logic [7:0] bad [5] = '{8'h07, 8'h17, 8'h01, 8'h57, 8'h68};
		foreach (bad[i]) begin
			@(posedge core_clk);
			start <= 1'b1;
			cmd <= {bad[i], 16'h1245};
			@(posedge core_clk);
			start <= 1'b0;
			@(negedge core_clk);
			chk({illegal_q, busy_q}, 2'h2);
			@(negedge core_clk);
			chk({illegal_q, done_q}, 2'h0);
		end
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		chk({busy_q, done_q, illegal_q, flags_we_q, rf_rd_req_q, rf_wr_q.en}, 6'h00);
		t_illegal();
		t_groups(0);
		t_edges();
		t_groups(2);
		t_band();
		results();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		results();
	end
endmodule

bind add_and_bitlogic_alu alu_port_checker alu_port_checker_inst (.*);
